// ### rtl/lock_ctrl_pkg.sv
package lock_ctrl_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_LOCK_STATUS = 16'hf600;
  localparam logic [15:0] IDX_CONTROL = 16'hf601;
  localparam logic [15:0] IDX_DECODE = 16'hf602;
  localparam logic [15:0] IDX_EVENT_STATUS = 16'hf610;
  localparam logic [15:0] IDX_EVENT_MASK = 16'hf611;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LOCK_BIT = 0;
  localparam int QUICK_BIT = 3;
  localparam int HOLD_BIT = 2;
  localparam int LEN_SEL_LSB = 0;
  localparam int RIGHT_LEN_LSB = 6;
  localparam int LEFT_LEN_LSB = 2;
  localparam int SCHEME_BIT = 1;
  localparam int AUDIO_TYPE_BIT = 0;
  localparam int EV_GAINED = 0;
  localparam int EV_LOST = 1;
  localparam int EV_DECODE = 2;
  localparam int EV_W = 3;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] CONTROL_RST = 4'h0;
  localparam logic [9:0] DECODE_RST = 10'h000;
  localparam logic [EV_W-1:0] EVENT_RST = 3'h0;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;
  localparam int NORMAL_LOCK_COUNT = 64;
  localparam int QUICK_LOCK_COUNT = 8;

  // ----------------------------------------------------------------
  // word lengths, selector and detected-length codes
  // ----------------------------------------------------------------
  localparam logic [4:0] BITS_16 = 5'h10;
  localparam logic [4:0] BITS_17 = 5'h11;
  localparam logic [4:0] BITS_18 = 5'h12;
  localparam logic [4:0] BITS_19 = 5'h13;
  localparam logic [4:0] BITS_20 = 5'h14;
  localparam logic [4:0] BITS_21 = 5'h15;
  localparam logic [4:0] BITS_22 = 5'h16;
  localparam logic [4:0] BITS_23 = 5'h17;
  localparam logic [4:0] BITS_24 = 5'h18;

  localparam logic [3:0] CODE_16 = 4'h2;
  localparam logic [3:0] CODE_17 = 4'hc;
  localparam logic [3:0] CODE_18 = 4'h4;
  localparam logic [3:0] CODE_19 = 4'h8;
  localparam logic [3:0] CODE_20 = 4'ha;
  localparam logic [3:0] CODE_21 = 4'hd;
  localparam logic [3:0] CODE_22 = 4'h5;
  localparam logic [3:0] CODE_23 = 4'h9;
  localparam logic [3:0] CODE_24 = 4'hb;
  localparam logic [3:0] CODE_20_WIDE = 4'h3;

  typedef enum logic [1:0] {
    LEN_24 = 2'h0,
    LEN_20 = 2'h1,
    LEN_16 = 2'h2,
    LEN_AUTO = 2'h3
  } word_len_sel_t;

  // lock tracker, gray along hunt -> count -> locked
  typedef enum logic [1:0] {
    ST_HUNT = 2'h0,
    ST_COUNT = 2'h1,
    ST_LOCKED = 2'h3
  } lock_state_t;

  // ----------------------------------------------------------------
  // carriers, laid out as their register bits
  // ----------------------------------------------------------------
  typedef struct packed {
    logic quick_acquire_sel;
    logic frame_clock_hold_sel;
    word_len_sel_t output_word_len_sel;
  } ctrl_t;

  typedef struct packed {
    logic [3:0] right_detected_len;
    logic [3:0] left_detected_len;
    logic packed_scheme_flag;
    logic nonaudio_flag;
  } stream_info_t;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
    reg_addr = {idx, 2'h0};
  endfunction

endpackage

// ### rtl/word_len_decode.sv
`timescale 1ns/100ps
module word_len_decode
  import lock_ctrl_pkg::*;
(
  input wire logic [3:0] code,
  output logic [4:0] len_bits,
  output logic known
);

  // ----------------------------------------------------------------
  // detected-length code to bit count
  // ----------------------------------------------------------------
  // codes outside the table report unknown so auto mode can fall back
  always_comb
  begin
    known = 1'b1;
    unique case (code)
      CODE_16: len_bits = BITS_16;
      CODE_17: len_bits = BITS_17;
      CODE_18: len_bits = BITS_18;
      CODE_19: len_bits = BITS_19;
      CODE_20: len_bits = BITS_20;
      CODE_21: len_bits = BITS_21;
      CODE_22: len_bits = BITS_22;
      CODE_23: len_bits = BITS_23;
      CODE_24: len_bits = BITS_24;
      CODE_20_WIDE: len_bits = BITS_20;
      default:
      begin
        len_bits = BITS_24;
        known = 1'b0;
      end
    endcase
  end

endmodule

// ### rtl/spdif_rx_lock_ctrl_decode.sv
`timescale 1ns/100ps
module spdif_rx_lock_ctrl_decode
  import lock_ctrl_pkg::*;
#(
  parameter int NORMAL_COUNT = NORMAL_LOCK_COUNT,
  parameter int QUICK_COUNT = QUICK_LOCK_COUNT
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [lock_ctrl_pkg::ADDR_W-1:0] addr,
  input wire logic [lock_ctrl_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [lock_ctrl_pkg::DATA_W-1:0] rdata,
  input wire logic sample_strobe,
  input wire logic sample_valid,
  input wire logic loss_detect,
  input wire logic info_strobe,
  input wire lock_ctrl_pkg::stream_info_t info_in,
  input wire logic frame_clk_in,
  output logic frame_clk_out,
  output logic locked,
  output logic [4:0] word_len,
  output logic irq
);

  import lock_ctrl_pkg::*;

  localparam int CNT_W = $clog2(NORMAL_COUNT + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ctrl_t ctrl_q;
  stream_info_t decode_q;
  lock_state_t state_q;
  lock_state_t state_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] target;
  logic [EV_W-1:0] ev_q;
  logic [EV_W-1:0] ev_d;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic [EV_W-1:0] mask_q;
  logic [EV_W-1:0] mask_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] read_value;
  logic locked_q;
  logic frame_clk_q;
  logic [4:0] word_len_q;
  logic [4:0] word_len_d;
  logic irq_q;
  logic good_sample;
  logic bad_sample;
  logic lose_now;
  logic gain_now;
  logic hit_control;
  logic hit_event;
  logic hit_mask;
  logic [4:0] left_bits;
  logic [4:0] right_bits;
  logic left_known;
  logic right_known;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  // only the control register and the event pair decode for writes
  assign hit_control = wr_en && (addr == reg_addr(IDX_CONTROL));
  assign hit_event = wr_en && (addr == reg_addr(IDX_EVENT_STATUS));
  assign hit_mask = wr_en && (addr == reg_addr(IDX_EVENT_MASK));

  // control register; reserved bits are dropped on write
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= ctrl_t'(CONTROL_RST);
    end
    else if (hit_control)
    begin
      ctrl_q <= ctrl_t'(wdata[3:0]);
    end
  end

  // interrupt mask, same layout as the event status
  always_comb
  begin
    mask_d = mask_q;
    if (hit_mask)
    begin
      mask_d = wdata[EV_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mask_q <= MASK_RST;
    end
    else
    begin
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // lock acquisition
  // ----------------------------------------------------------------
  // a sample is judged only on its strobe; loss_detect also breaks a run
  assign good_sample = sample_strobe && sample_valid && !loss_detect;
  assign bad_sample = (sample_strobe && !sample_valid) || loss_detect;

  // the threshold follows the quick bit live, even mid-run
  assign target = ctrl_q.quick_acquire_sel ? CNT_W'(QUICK_COUNT) : CNT_W'(NORMAL_COUNT);

  // next lock state and run length
  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    unique case (state_q)
      ST_HUNT:
      begin
        if (good_sample)
        begin
          count_d = {{(CNT_W-1){1'b0}}, 1'b1};
          state_d = (target <= count_d) ? ST_LOCKED : ST_COUNT;
        end
      end
      ST_COUNT:
      begin
        if (bad_sample)
        begin
          count_d = '0;
          state_d = ST_HUNT;
        end
        else if (good_sample)
        begin
          count_d = count_q + 1'b1;
          if (count_d >= target)
          begin
            state_d = ST_LOCKED;
          end
        end
      end
      ST_LOCKED:
      begin
        if (bad_sample)
        begin
          count_d = '0;
          state_d = ST_HUNT;
        end
      end
      default:
      begin
        count_d = '0;
        state_d = ST_HUNT;
      end
    endcase
  end

  assign lose_now = (state_q == ST_LOCKED) && (state_d != ST_LOCKED);
  assign gain_now = (state_q != ST_LOCKED) && (state_d == ST_LOCKED);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_HUNT;
      count_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  // lock flag changes on the same edge as the tracker
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      locked_q <= 1'b0;
    end
    else
    begin
      locked_q <= (state_d == ST_LOCKED);
    end
  end

  // ----------------------------------------------------------------
  // recovered frame clock
  // ----------------------------------------------------------------
  // weak mode gates the clock low on the very edge lock is lost and until
  // relock; strong mode passes it through and accepts corrupt frames
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      frame_clk_q <= 1'b0;
    end
    else if (ctrl_q.frame_clock_hold_sel && (state_d != ST_LOCKED))
    begin
      frame_clk_q <= 1'b0;
    end
    else
    begin
      frame_clk_q <= frame_clk_in;
    end
  end

  // ----------------------------------------------------------------
  // stream decode
  // ----------------------------------------------------------------
  // fields hold their last value across a loss so software can inspect it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      decode_q <= stream_info_t'(DECODE_RST);
    end
    else if (info_strobe)
    begin
      decode_q <= info_in;
    end
  end

  word_len_decode left_dec
  (
    .code(decode_q.left_detected_len),
    .len_bits(left_bits),
    .known(left_known)
  );

  word_len_decode right_dec
  (
    .code(decode_q.right_detected_len),
    .len_bits(right_bits),
    .known(right_known)
  );

  // ----------------------------------------------------------------
  // delivered word length
  // ----------------------------------------------------------------
  // auto prefers the left code, then the right, else full 24 bits so no
  // audio bits are thrown away on an unreadable channel status
  always_comb
  begin
    word_len_d = BITS_24;
    unique case (ctrl_q.output_word_len_sel)
      LEN_24: word_len_d = BITS_24;
      LEN_20: word_len_d = BITS_20;
      LEN_16: word_len_d = BITS_16;
      LEN_AUTO:
      begin
        if (left_known)
        begin
          word_len_d = left_bits;
        end
        else if (right_known)
        begin
          word_len_d = right_bits;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      word_len_q <= BITS_24;
    end
    else
    begin
      word_len_q <= word_len_d;
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  // set wins over a clear in the same cycle
  always_comb
  begin
    ev_set = '0;
    ev_set[EV_GAINED] = gain_now;
    ev_set[EV_LOST] = lose_now;
    ev_set[EV_DECODE] = info_strobe && (info_in != decode_q);
    ev_clr = hit_event ? wdata[EV_W-1:0] : '0;
    ev_d = (ev_q & ~ev_clr) | ev_set;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ev_q <= EVENT_RST;
    end
    else
    begin
      ev_q <= ev_d;
    end
  end

  // registered, so it tracks status and mask with no extra cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(ev_d & mask_d);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped addresses and reserved bits read zero
  always_comb
  begin
    read_value = '0;
    if (addr == reg_addr(IDX_LOCK_STATUS))
    begin
      read_value[LOCK_BIT] = locked_q;
    end
    else if (addr == reg_addr(IDX_CONTROL))
    begin
      read_value[QUICK_BIT:LEN_SEL_LSB] = ctrl_q;
    end
    else if (addr == reg_addr(IDX_DECODE))
    begin
      read_value[RIGHT_LEN_LSB+3:RIGHT_LEN_LSB] = decode_q.right_detected_len;
      read_value[LEFT_LEN_LSB+3:LEFT_LEN_LSB] = decode_q.left_detected_len;
      read_value[SCHEME_BIT] = decode_q.packed_scheme_flag;
      read_value[AUDIO_TYPE_BIT] = decode_q.nonaudio_flag;
    end
    else if (addr == reg_addr(IDX_EVENT_STATUS))
    begin
      read_value[EV_W-1:0] = ev_q;
    end
    else if (addr == reg_addr(IDX_EVENT_MASK))
    begin
      read_value[EV_W-1:0] = mask_q;
    end
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= rd_en ? read_value : '0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = rdata_q;
  assign frame_clk_out = frame_clk_q;
  assign locked = locked_q;
  assign word_len = word_len_q;
  assign irq = irq_q;

endmodule

// ### dv/lock_ctrl_assertions.sv
`timescale 1ns/100ps
module lock_ctrl_assertions
  import lock_ctrl_pkg::*;
#(
  parameter int NORMAL_COUNT = NORMAL_LOCK_COUNT,
  parameter int QUICK_COUNT = QUICK_LOCK_COUNT
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [lock_ctrl_pkg::ADDR_W-1:0] addr,
  input wire logic [lock_ctrl_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [lock_ctrl_pkg::DATA_W-1:0] rdata,
  input wire logic sample_strobe,
  input wire logic sample_valid,
  input wire logic loss_detect,
  input wire logic frame_clk_in,
  input wire logic frame_clk_out,
  input wire logic locked,
  input wire logic [4:0] word_len
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // shadow of control and of the current run of good samples
  // ------------------------------------------------------------
  logic [3:0] ctl_q;
  logic [7:0] run_q;
  logic good;
  logic bad;
  logic [7:0] tgt;
  assign good = sample_strobe && sample_valid && !loss_detect;
  assign bad = loss_detect || (sample_strobe && !sample_valid);
  assign tgt = ctl_q[QUICK_BIT] ? 8'(QUICK_COUNT) : 8'(NORMAL_COUNT);
  always_ff @(posedge clock or posedge rst)
    if (rst) ctl_q <= CONTROL_RST;
    else if (wr_en && addr == {IDX_CONTROL, 2'h0}) ctl_q <= wdata[3:0];
  // run saturates below the top so the +1 compare never wraps
  always_ff @(posedge clock or posedge rst)
    if (rst) run_q <= 8'h00;
    else if (bad) run_q <= 8'h00;
    else if (good && run_q != 8'hfe) run_q <= run_q + 8'h01;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_lock_rise;
    !locked && good && run_q + 8'h01 >= tgt |=> locked;
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock not taken at full run");
  property p_rise_cause;
    $rose(locked) |-> $past(good && run_q + 8'h01 >= tgt);
  endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("lock taken before full run");
  property p_lock_fall;
    locked && bad |=> !locked;
  endproperty
  a_lock_fall: assert property (p_lock_fall) else $error("lock kept after loss");
  property p_fall_cause;
    $fell(locked) |-> $past(bad);
  endproperty
  a_fall_cause: assert property (p_fall_cause) else $error("lock dropped without cause");
  property p_hold_stop;
    $past(ctl_q[HOLD_BIT]) && !locked |-> !frame_clk_out;
  endproperty
  a_hold_stop: assert property (p_hold_stop) else $error("frame clock runs unlocked in hold mode");
  property p_hold_pass;
    !$past(rst) && (!$past(ctl_q[HOLD_BIT]) || locked) |-> frame_clk_out == $past(frame_clk_in);
  endproperty
  a_hold_pass: assert property (p_hold_pass) else $error("frame clock not passed");
  property p_rdata_idle;
    !$past(rd_en) |-> rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_lock_read;
    $past(rd_en && addr == {IDX_LOCK_STATUS, 2'h0}) |-> rdata == {15'h0000, $past(locked)};
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock status read wrong");
  property p_word_len_fixed;
    $past(ctl_q[1:0]) != LEN_AUTO |-> word_len == ($past(ctl_q[1:0]) == LEN_24 ? BITS_24 :
      $past(ctl_q[1:0]) == LEN_20 ? BITS_20 : BITS_16);
  endproperty
  a_word_len_fixed: assert property (p_word_len_fixed) else $error("fixed word length wrong");
endmodule

// ### dv/spdif_tx_model.sv
`timescale 1ns/100ps
module spdif_tx_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic en,
  input wire logic bad,
  input wire logic lose,
  output logic sample_strobe,
  output logic sample_valid,
  output logic loss_detect,
  output logic frame_clk_in
);
  logic fclk_q;
  // recovered frame clock toggles every cycle so a stuck output shows at once
  always_ff @(posedge clock or posedge rst)
    if (rst) fclk_q <= 1'b0;
    else fclk_q <= !fclk_q;
  // validity is meaningless between samples, so it carries a moving pattern there
  assign sample_strobe = en;
  assign sample_valid = en ? !bad : fclk_q;
  assign loss_detect = lose;
  assign frame_clk_in = fclk_q;
endmodule

// ### dv/spdif_rx_lock_ctrl_decode_tb.sv
`timescale 1ns/100ps
module spdif_rx_lock_ctrl_decode_tb;
  import lock_ctrl_pkg::*;
  localparam logic [17:0] A_LOCK = {IDX_LOCK_STATUS, 2'h0};
  localparam logic [17:0] A_CTRL = {IDX_CONTROL, 2'h0};
  localparam logic [17:0] A_DEC = {IDX_DECODE, 2'h0};
  localparam logic [17:0] A_EV = {IDX_EVENT_STATUS, 2'h0};
  localparam logic [17:0] A_MASK = {IDX_EVENT_MASK, 2'h0};
  localparam int NC = 64;
  localparam int QC = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [17:0] addr = 18'h00000;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic info_strobe = 1'b0;
  stream_info_t info_in = 10'h000;
  logic en = 1'b0;
  logic bad = 1'b0;
  logic lose = 1'b0;
  logic [15:0] rdata;
  logic sample_strobe, sample_valid, loss_detect, frame_clk_in, frame_clk_out, locked, irq, f;
  logic [4:0] word_len;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [3:0] codes [10] = '{CODE_16, CODE_17, CODE_18, CODE_19, CODE_20, CODE_21, CODE_22, CODE_23, CODE_24,
    CODE_20_WIDE};
  logic [4:0] lens [10] = '{BITS_16, BITS_17, BITS_18, BITS_19, BITS_20, BITS_21, BITS_22, BITS_23, BITS_24,
    BITS_20};
  logic [4:0] fixed [3] = '{BITS_24, BITS_20, BITS_16};
  always #20 clock = !clock;
  spdif_tx_model TX (.clock(clock), .rst(rst), .en(en), .bad(bad), .lose(lose), .sample_strobe(sample_strobe),
    .sample_valid(sample_valid), .loss_detect(loss_detect), .frame_clk_in(frame_clk_in));
  spdif_rx_lock_ctrl_decode #(.NORMAL_COUNT(NC), .QUICK_COUNT(QC)) DUT (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sample_strobe(sample_strobe),
    .sample_valid(sample_valid), .loss_detect(loss_detect), .info_strobe(info_strobe), .info_in(info_in),
    .frame_clk_in(frame_clk_in), .frame_clk_out(frame_clk_out), .locked(locked), .word_len(word_len), .irq(irq));
  // ------------------------------------------------------------
  // bus, stream and check helpers
  // ------------------------------------------------------------
  task automatic wrap_up;
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [17:0] a, input logic [15:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [17:0] a, input logic [15:0] exp, input string name);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask
  // exactly n samples reach the receiver, one per cycle; a strobe-free gap
  // cycle between two runs neither extends nor breaks the current run
  task automatic run(input int n, input logic b);
    @(posedge clock);
    bad <= b;
    en <= 1'b1;
    repeat (n) @(posedge clock);
    en <= 1'b0;
    bad <= 1'b0;
    #1;
  endtask
  task automatic drop;
    @(posedge clock);
    lose <= 1'b1;
    @(posedge clock);
    lose <= 1'b0;
    #1;
    chk("locked", 16'h0000, 16'(locked));
  endtask
  task automatic info(input stream_info_t v);
    @(posedge clock);
    info_in <= v;
    info_strobe <= 1'b1;
    @(posedge clock);
    info_strobe <= 1'b0;
    step(2);
  endtask
  // hang guard: the whole sequence needs well under two thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    chk("word_len", 16'(BITS_24), 16'(word_len));
    rd(A_LOCK, 16'h0000, "lock_status");
    rd(A_DEC, 16'h0000, "decode");
    rd({16'hf603, 2'h0}, 16'h0000, "unmapped");
    wr(A_LOCK, 16'hffff);
    wr(A_DEC, 16'hffff);
    wr(A_CTRL, 16'hfff0);
    rd(A_LOCK, 16'h0000, "lock_status");
    rd(A_DEC, 16'h0000, "decode");
    rd(A_CTRL, 16'h0000, "control");
    wr(A_MASK, 16'h0001);
    run(NC - 1, 1'b0);
    chk("locked", 16'h0000, 16'(locked));
    run(1, 1'b0);
    chk("locked", 16'h0001, 16'(locked));
    rd(A_LOCK, 16'h0001, "lock_status");
    step(1);
    chk("irq", 16'h0001, 16'(irq));
    wr(A_EV, 16'h0001);
    step(1);
    chk("irq", 16'h0000, 16'(irq));
    // hold mode while locked passes the clock, then stops it on loss
    wr(A_CTRL, 16'h000c);
    step(1);
    f = frame_clk_out;
    step(1);
    chk("frame_clk_out", 16'(!f), 16'(frame_clk_out));
    drop();
    for (int i = 0; i < 4; i++)
    begin
      chk("frame_clk_out", 16'h0000, 16'(frame_clk_out));
      step(1);
    end
    rd(A_EV, 16'h0002, "event_status");
    chk("irq", 16'h0000, 16'(irq));
    run(5, 1'b0);
    run(1, 1'b1);
    run(QC - 1, 1'b0);
    chk("locked", 16'h0000, 16'(locked));
    run(1, 1'b0);
    chk("locked", 16'h0001, 16'(locked));
    wr(A_CTRL, 16'h0008);
    drop();
    step(1);
    f = frame_clk_out;
    step(1);
    chk("frame_clk_out", 16'(!f), 16'(frame_clk_out));
    for (int i = 0; i < 3; i++)
    begin
      wr(A_CTRL, 16'(i));
      step(1);
      chk("word_len", 16'(fixed[i]), 16'(word_len));
    end
    // automatic length over every code, flags varied along the way
    wr(A_EV, 16'h0007);
    wr(A_CTRL, 16'h0003);
    for (int i = 0; i < 10; i++)
    begin
      info({codes[9 - i], codes[i], i[0], i[1]});
      chk("word_len", 16'(lens[i]), 16'(word_len));
      rd(A_DEC, {6'h00, codes[9 - i], codes[i], i[0], i[1]}, "decode");
    end
    info({CODE_17, 4'h0, 2'h0});
    chk("word_len", 16'(BITS_17), 16'(word_len));
    info(10'h000);
    chk("word_len", 16'(BITS_24), 16'(word_len));
    rd(A_EV, 16'h0004, "event_status");
    wr(A_MASK, 16'h0004);
    step(1);
    chk("irq", 16'h0001, 16'(irq));
    wr(A_MASK, 16'h0000);
    step(1);
    chk("irq", 16'h0000, 16'(irq));
    wrap_up();
  end
endmodule
bind spdif_rx_lock_ctrl_decode lock_ctrl_assertions #(.NORMAL_COUNT(NORMAL_COUNT), .QUICK_COUNT(QUICK_COUNT)) CHK (
  .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .sample_strobe(sample_strobe), .sample_valid(sample_valid), .loss_detect(loss_detect),
  .frame_clk_in(frame_clk_in), .frame_clk_out(frame_clk_out), .locked(locked), .word_len(word_len));
